// ==== rtl/srxeh_consts.vh ====
// Purpose: constants for the serial receive error handling unit
// Assumes: 40 MHz system clock
// Notes:   macros only, no logic
`ifndef SRXEH_CONSTS_VH
`define SRXEH_CONSTS_VH
// Oversampling ratio and sample point
`define SRXEH_OVERSAMPLE  16
`define SRXEH_SAMPLE_TICK 4'h7
`define SRXEH_TICK_LAST   4'hF
// Default bit-rate divider (system clocks per basic-clock tick)
`define SRXEH_DIV_DEFAULT 16'h0001
// Data bits per frame (last data bit index is this minus one)
`define SRXEH_DATA_BITS   4'h8
// Receive state codes
`define SRXEH_RX_IDLE     3'h0
`define SRXEH_RX_START    3'h1
`define SRXEH_RX_DATA     3'h2
`define SRXEH_RX_PAR      3'h3
`define SRXEH_RX_STOP     3'h4
// Reset values
`define SRXEH_RST_FLAG    1'b0
`define SRXEH_RST_TEMPTY  1'b1
`endif

// ==== rtl/srxeh_top.v ====
// Purpose: serial unit receive path with error flags, transmit pin control
// Assumes: one clock, control and status bits are plain ports
// Notes:   asynchronous mode receives; synchronous mode only gates transmit start
`timescale 1ns/1ps
`include "srxeh_consts.vh"
module srxeh_top #(
    parameter [15:0] DIV = `SRXEH_DIV_DEFAULT
)(
    input  wire       CLK_I,
    input  wire       RST_N_I,
    input  wire       RX_PIN_I,
    input  wire       RECEIVER_ON_I,
    input  wire       TRANSMITTER_ON_I,
    input  wire       SYNC_MODE_I,
    input  wire       PARITY_ON_I,
    input  wire       PARITY_ODD_I,
    input  wire       HOLD_READ_I,
    input  wire       CLEAR_OVERRUN_I,
    input  wire       CLEAR_FRAMING_I,
    input  wire       CLEAR_PARITY_I,
    input  wire       TX_WRITE_I,
    input  wire [7:0] TX_DATA_I,
    input  wire       PORT_DIRECTION_I,
    input  wire       PORT_OUTPUT_VALUE_I,
    output wire [7:0] HOLD_DATA_O,
    output wire       RECEIVE_FULL_FLAG_O,
    output wire       OVERRUN_FLAG_O,
    output wire       FRAMING_ERROR_FLAG_O,
    output wire       PARITY_ERROR_FLAG_O,
    output wire       RECEIVE_ERROR_INTERRUPT_O,
    output wire       TRANSMIT_EMPTY_FLAG_O,
    output wire       TX_PIN_O,
    output wire       TX_PIN_OE_O,
    output wire       RX_BUSY_O
);

    //**************************************************************
    // Pin synchroniser and basic clock
    //**************************************************************
    reg        rx_meta_q;
    reg        rx_sync_q;
    reg        rx_prev_q;
    reg [15:0] div_cnt_q;
    wire       tick = (div_cnt_q == DIV - 16'h0001);

    // Two-stage synchroniser and previous value for edge detection
    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end
        else
        begin
            rx_meta_q <= RX_PIN_I;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    always @(posedge CLK_I)
    begin
        if (!RST_N_I || tick)
            div_cnt_q <= 16'h0000;
        else
            div_cnt_q <= div_cnt_q + 16'h0001;
    end

    //**************************************************************
    // Receive state machine
    //**************************************************************
    reg [2:0] st_q;
    reg [3:0] tck_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg       par_q;
    reg [7:0] hold_q;
    reg       full_q;
    reg       ovr_q;
    reg       fer_q;
    reg       per_q;
    reg       frame_done;
    reg       fer_now;
    reg       per_now;

    wire sample = tick && (tck_q == `SRXEH_SAMPLE_TICK);
    wire fall   = rx_prev_q && !rx_sync_q;

    // start sync on falling edge, sample at 8th tick
    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            st_q    <= `SRXEH_RX_IDLE;
            tck_q   <= 4'h0;
            bit_q   <= 4'h0;
            shift_q <= 8'h00;
            par_q   <= 1'b0;
        end
        else if (!RECEIVER_ON_I || SYNC_MODE_I)
            st_q <= `SRXEH_RX_IDLE;
        else
        begin
            if (tick)
                tck_q <= tck_q + 4'h1;
            case (st_q)
                `SRXEH_RX_IDLE:
                    if (fall)
                    begin
                        st_q  <= `SRXEH_RX_START;
                        tck_q <= 4'h0;
                    end
                `SRXEH_RX_START:
                    if (sample)
                    begin
                        st_q  <= rx_sync_q ? `SRXEH_RX_IDLE : `SRXEH_RX_DATA;
                        bit_q <= 4'h0;
                        par_q <= PARITY_ODD_I;
                    end
                `SRXEH_RX_DATA:
                    if (sample)
                    begin
                        shift_q <= {rx_sync_q, shift_q[7:1]};
                        par_q   <= par_q ^ rx_sync_q;
                        bit_q   <= bit_q + 4'h1;
                        if (bit_q == `SRXEH_DATA_BITS - 4'h1)
                            st_q <= PARITY_ON_I ? `SRXEH_RX_PAR : `SRXEH_RX_STOP;
                    end
                `SRXEH_RX_PAR:
                    if (sample)
                    begin
                        par_q <= par_q ^ rx_sync_q;
                        st_q  <= `SRXEH_RX_STOP;
                    end
                `SRXEH_RX_STOP:
                    // return to idle even on break, keep receiving
                    if (sample)
                        st_q <= `SRXEH_RX_IDLE;
                default:
                    st_q <= `SRXEH_RX_IDLE;
            endcase
        end
    end

    // Frame completion decode
    always @*
    begin
        frame_done = RECEIVER_ON_I && !SYNC_MODE_I && sample && (st_q == `SRXEH_RX_STOP);
        // break gives zero stop bit, framing error
        fer_now    = !rx_sync_q;
        per_now    = PARITY_ON_I && par_q;
    end

    //**************************************************************
    // Holding register and status flags
    //**************************************************************
    // overrun when full flag still set at frame end
    wire ovr_now = frame_done && full_q;

    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
            hold_q <= 8'h00;
        else if (frame_done && !full_q)
            hold_q <= shift_q;
    end

    // full flag: set on error-free load only, read clears
    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
            full_q <= `SRXEH_RST_FLAG;
        else if (frame_done && !full_q && !fer_now && !per_now)
            full_q <= 1'b1;
        else if (HOLD_READ_I)
            full_q <= 1'b0;
    end

    // error flags cleared only by software, set wins over clear
    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            ovr_q <= `SRXEH_RST_FLAG;
            fer_q <= `SRXEH_RST_FLAG;
            per_q <= `SRXEH_RST_FLAG;
        end
        else
        begin
            if (ovr_now)
                ovr_q <= 1'b1;
            else if (CLEAR_OVERRUN_I)
                ovr_q <= 1'b0;
            // framing error sets again after clear
            if (frame_done && fer_now)
                fer_q <= 1'b1;
            else if (CLEAR_FRAMING_I)
                fer_q <= 1'b0;
            if (frame_done && per_now)
                per_q <= 1'b1;
            else if (CLEAR_PARITY_I)
                per_q <= 1'b0;
        end
    end

    //**************************************************************
    // Transmit unit
    //**************************************************************
    reg [7:0] tdata_q;
    reg       tempty_q;
    reg [9:0] tshift_q;
    reg [3:0] tbits_q;
    reg [3:0] ttck_q;
    wire      any_err = ovr_q || fer_q || per_q;
    // synchronous mode blocks start while errors stand
    wire      tx_start = TRANSMITTER_ON_I && !tempty_q && (tbits_q == 4'h0)
                         && !(SYNC_MODE_I && any_err);

    // transmitter-off resets transmit unit at once
    always @(posedge CLK_I)
    begin
        if (!RST_N_I || !TRANSMITTER_ON_I)
        begin
            tempty_q <= `SRXEH_RST_TEMPTY;
            tdata_q  <= 8'h00;
            tshift_q <= 10'h3FF;
            tbits_q  <= 4'h0;
            ttck_q   <= 4'h0;
        end
        else
        begin
            if (TX_WRITE_I)
            begin
                tdata_q  <= TX_DATA_I;
                tempty_q <= 1'b0;
            end
            else if (tx_start)
                tempty_q <= 1'b1;
            if (tx_start)
            begin
                tshift_q <= {1'b1, tdata_q, 1'b0};
                tbits_q  <= 4'hA;
                ttck_q   <= 4'h0;
            end
            else if (tick && tbits_q != 4'h0)
            begin
                ttck_q <= ttck_q + 4'h1;
                if (ttck_q == `SRXEH_TICK_LAST)
                begin
                    tshift_q <= {1'b1, tshift_q[9:1]};
                    tbits_q  <= tbits_q - 4'h1;
                end
            end
        end
    end

    //**************************************************************
    // Outputs
    //**************************************************************
    // no serial clock pin driven here, so no switch glitch
    // pin from port settings while transmitter off
    assign TX_PIN_O    = TRANSMITTER_ON_I ? tshift_q[0] : PORT_OUTPUT_VALUE_I;
    assign TX_PIN_OE_O = TRANSMITTER_ON_I ? 1'b1 : PORT_DIRECTION_I;
    assign RECEIVE_ERROR_INTERRUPT_O = any_err;
    assign HOLD_DATA_O           = hold_q;
    assign RECEIVE_FULL_FLAG_O   = full_q;
    assign OVERRUN_FLAG_O        = ovr_q;
    assign FRAMING_ERROR_FLAG_O  = fer_q;
    assign PARITY_ERROR_FLAG_O   = per_q;
    assign TRANSMIT_EMPTY_FLAG_O = tempty_q;
    assign RX_BUSY_O             = (st_q != `SRXEH_RX_IDLE);

endmodule

// ==== test/srxeh_monitor.sv ====
// Purpose: port checker for the serial receive error unit
// Assumes: one clock, synchronous active-low reset
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ps
module srxeh_monitor #(
    parameter [15:0] DIV = 16'h0001
)(
    input wire       CLK_I,
    input wire       RST_N_I,
    input wire       RX_PIN_I,
    input wire       RECEIVER_ON_I,
    input wire       TRANSMITTER_ON_I,
    input wire       SYNC_MODE_I,
    input wire       HOLD_READ_I,
    input wire       CLEAR_FRAMING_I,
    input wire       PORT_DIRECTION_I,
    input wire       PORT_OUTPUT_VALUE_I,
    input wire [7:0] HOLD_DATA_O,
    input wire       RECEIVE_FULL_FLAG_O,
    input wire       OVERRUN_FLAG_O,
    input wire       FRAMING_ERROR_FLAG_O,
    input wire       PARITY_ERROR_FLAG_O,
    input wire       RECEIVE_ERROR_INTERRUPT_O,
    input wire       TRANSMIT_EMPTY_FLAG_O,
    input wire       TX_PIN_O,
    input wire       TX_PIN_OE_O,
    input wire       RX_BUSY_O
);
    // ****************
    // Port relations
    // ****************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    // Error request is the or of the three flags
    chk_irq_or: assert property (
        RECEIVE_ERROR_INTERRUPT_O ==
        (OVERRUN_FLAG_O | FRAMING_ERROR_FLAG_O | PARITY_ERROR_FLAG_O)) else $error("irq");
    chk_pin_port: assert property (
        !TRANSMITTER_ON_I |-> TX_PIN_O == PORT_OUTPUT_VALUE_I
        && TX_PIN_OE_O == PORT_DIRECTION_I) else $error("port pin");
    chk_overrun_keeps: assert property (
        $rose(OVERRUN_FLAG_O) |-> $stable(HOLD_DATA_O) && RECEIVE_FULL_FLAG_O) else $error("ovr");
    chk_parity_loads: assert property (
        $rose(PARITY_ERROR_FLAG_O) && !$rose(OVERRUN_FLAG_O) && !$past(HOLD_READ_I)
        |-> $stable(RECEIVE_FULL_FLAG_O))
        else $error("par load");
    chk_read_clears: assert property (
        HOLD_READ_I && RECEIVE_FULL_FLAG_O |=> !RECEIVE_FULL_FLAG_O || $changed(HOLD_DATA_O))
        else $error("read");
    chk_framing_sticky: assert property (
        $fell(FRAMING_ERROR_FLAG_O) |-> $past(CLEAR_FRAMING_I)) else $error("fer");
    chk_sync_blocks: assert property (
        SYNC_MODE_I && TRANSMITTER_ON_I && RECEIVE_ERROR_INTERRUPT_O && !TRANSMIT_EMPTY_FLAG_O
        |=> !TRANSMITTER_ON_I || !TRANSMIT_EMPTY_FLAG_O) else $error("sync tx");
    chk_start_seen: assert property (
        $fell(RX_PIN_I) && !RX_BUSY_O && RECEIVER_ON_I && !SYNC_MODE_I |-> ##[2:5] RX_BUSY_O)
        else $error("start");
endmodule
bind srxeh_top srxeh_monitor #(.DIV(DIV)) u_mon (.*);

// ==== test/srxeh_station.sv ====
// Purpose: remote station driving the receive line
// Assumes: DIV of 1, so a bit lasts 16 clocks
// Notes:   line idles at mark; send is called at a clock edge
`timescale 1ns/1ps
module srxeh_station #(
    parameter integer BIT_CLKS = 16
)(
    input  wire clk_i,
    output reg  line_o
);
    // ****************
    // Frame sender
    // ****************
    initial line_o = 1'b1;

    // One bit held for a full bit time
    task hold_bit(input b);
        begin
            line_o <= b;
            repeat (BIT_CLKS) @(posedge clk_i);
        end
    endtask

    // start, data LSB first, parity, stop, mark
    task send(input [7:0] d, input par_on, input par, input stop);
        integer i;
        begin
            hold_bit(1'b0);
            for (i = 0; i < 8; i = i + 1)
                hold_bit(d[i]);
            if (par_on)
                hold_bit(par);
            hold_bit(stop);
            hold_bit(1'b1);
        end
    endtask
endmodule

// ==== test/srxeh_top_test.sv ====
// Purpose: self-checking bench for the serial receive error unit
// Assumes: DIV of 1
// Notes:   station model drives the receive line
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks = num_checks + 1; if ((a) !== (b)) begin \
    mismatches = mismatches + 1; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module srxeh_top_test;
    reg        clk = 1'b0, rst_n = 1'b0, rx_on = 1'b1, tx_on = 1'b0, sync = 1'b0;
    reg        par_on = 1'b0, par_odd = 1'b0, dir = 1'b1, val = 1'b1;
    reg  [4:0] pls = 5'h00;
    wire       rx_line, full, overrun_flag, framing_error_flag, parity_error_flag, irq, empty, pin, oe;
    wire [7:0] hold;
    integer    mismatches = 0, num_checks = 0, cycles = 0, i;

    // ****************
    // Harness
    // ****************
    // One full-rate clock, no subclock mode used
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    srxeh_station far (.clk_i(clk), .line_o(rx_line));
    srxeh_top #(.DIV(16'h0001)) dut (
        .CLK_I(clk), .RST_N_I(rst_n), .RX_PIN_I(rx_line), .RECEIVER_ON_I(rx_on),
        .TRANSMITTER_ON_I(tx_on), .SYNC_MODE_I(sync), .PARITY_ON_I(par_on),
        .PARITY_ODD_I(par_odd), .HOLD_READ_I(pls[0]), .CLEAR_OVERRUN_I(pls[1]),
        .CLEAR_FRAMING_I(pls[2]), .CLEAR_PARITY_I(pls[3]), .TX_WRITE_I(pls[4]),
        .TX_DATA_I(8'h00), .PORT_DIRECTION_I(dir), .PORT_OUTPUT_VALUE_I(val),
        .HOLD_DATA_O(hold), .RECEIVE_FULL_FLAG_O(full), .OVERRUN_FLAG_O(overrun_flag),
        .FRAMING_ERROR_FLAG_O(framing_error_flag), .PARITY_ERROR_FLAG_O(parity_error_flag),
        .RECEIVE_ERROR_INTERRUPT_O(irq), .TRANSMIT_EMPTY_FLAG_O(empty),
        .TX_PIN_O(pin), .TX_PIN_OE_O(oe), .RX_BUSY_O());

    // One-cycle strobes: read, clear overrun, framing, parity, write
    task pulse(input [4:0] m);
        begin
            pls <= m;
            @(posedge clk);
            pls <= 5'h00;
            @(posedge clk);
        end
    endtask

    // Verdict and end of run
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", num_checks, mismatches);
            if (mismatches == 0 && num_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    // Hang guard
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 4000)
        begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    end

    // Test sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        far.send(8'hA5, 1'b0, 1'b0, 1'b1);
        `CHK({hold, full, irq}, {8'hA5, 2'b10})
        pulse(5'h01);
        `CHK(full, 1'b0)
        $display("test plain frame done");
        par_on <= 1'b1;
        far.send(8'h5A, 1'b1, 1'b1, 1'b1);
        `CHK({hold, full, parity_error_flag, irq}, {8'h5A, 3'b011})
        pulse(5'h09);
        par_odd <= 1'b1;
        far.send(8'h81, 1'b1, 1'b1, 1'b1);
        `CHK({hold, parity_error_flag}, {8'h81, 1'b0})
        pulse(5'h01);
        far.send(8'h81, 1'b1, 1'b0, 1'b1);
        `CHK(parity_error_flag, 1'b1)
        pulse(5'h01);
        $display("test parity done");
        {par_on, rx_on, sync, tx_on} <= 4'b0011;
        pulse(5'h10);
        repeat (20) @(posedge clk);
        `CHK({parity_error_flag, empty}, 2'b10)
        pulse(5'h08);
        repeat (3) @(posedge clk);
        `CHK(empty, 1'b1)
        $display("test sync gate done");
        tx_on <= 1'b0;
        @(posedge clk);
        sync <= 1'b0;
        @(posedge clk);
        {tx_on, rx_on} <= 2'b11;
        pulse(5'h10);
        repeat (3) @(posedge clk);
        `CHK({oe, pin}, 2'b10)
        for (i = 0; i < 4; i = i + 1)
        begin
            {tx_on, dir, val} <= {1'b0, i[1:0]};
            repeat (2) @(posedge clk);
            `CHK({oe, pin}, i[1:0])
        end
        tx_on <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK({oe, pin, empty}, 3'b111)
        $display("test port pin done");
        far.send(8'h3C, 1'b0, 1'b0, 1'b1);
        far.send(8'hC3, 1'b0, 1'b0, 1'b1);
        `CHK({hold, full, overrun_flag}, {8'h3C, 2'b11})
        pulse(5'h01);
        `CHK({full, overrun_flag}, 2'b01)
        pulse(5'h02);
        $display("test overrun done");
        far.send(8'h00, 1'b0, 1'b0, 1'b0);
        `CHK({hold, full, framing_error_flag}, {8'h00, 2'b01})
        pulse(5'h05);
        far.send(8'h00, 1'b0, 1'b0, 1'b0);
        `CHK(framing_error_flag, 1'b1)
        pulse(5'h05);
        $display("test break done");
        wrap_up;
    end
endmodule
